// [core/asep_ctrl.sv]
// Host controller driving an asynchronous 16-bit static memory with
// byte lanes, deep-sleep pin and corrected-error flag.
// Assumes pin inputs are asynchronous; user side is on clk_i.
`timescale 1ns/1ns
`default_nettype none

module asep_ctrl #(
  parameter int DS_CYC   = asep_pkg::ASEP_DS_CYC,
  parameter int DSCA_CYC = asep_pkg::ASEP_DSCA_CYC
) (
  input  wire logic                             clk_i,
  input  wire logic                             reset_n_i,
  input  wire logic                             ce_i,
  // User request side
  input  wire logic                             req_valid_i,
  output logic                                  req_ready_o,
  input  wire logic                             req_write_i,
  input  wire logic [asep_pkg::ASEP_ADDR_W-1:0] req_addr_i,
  input  wire logic [asep_pkg::ASEP_DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]                       req_be_i,
  output logic                                  rsp_valid_o,
  output logic [asep_pkg::ASEP_DATA_W-1:0]      rsp_rdata_o,
  output logic                                  rsp_ecc_fix_o,
  input  wire logic                             sleep_req_i,
  output logic                                  awake_o,
  // Memory pins
  output logic [asep_pkg::ASEP_ADDR_W-1:0]      mem_addr_o,
  output logic                                  chip_select_n_o,
  output logic                                  drive_enable_n_o,
  output logic                                  write_strobe_n_o,
  output logic                                  low_byte_lane_n_o,
  output logic                                  high_byte_lane_n_o,
  output logic                                  deep_sleep_n_o,
  output logic [asep_pkg::ASEP_DATA_W-1:0]      mem_data_o,
  output logic                                  mem_data_oe_o,
  input  wire logic [asep_pkg::ASEP_DATA_W-1:0] mem_data_i,
  input  wire logic                             ecc_fixup_flag_i
);
  import asep_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    asep_state_e            state;
    logic [ASEP_ADDR_W-1:0] addr;
    logic [ASEP_DATA_W-1:0] wdata;
    logic                   data_oe;
    logic                   cs_n;
    logic                   oe_n;
    logic                   we_n;
    logic [1:0]             lanes_n;
    logic                   ds_n;
    logic [ASEP_DATA_W-1:0] sd1;
    logic [ASEP_DATA_W-1:0] sd2;
    logic                   sf1;
    logic                   sf2;
    logic [ASEP_DATA_W-1:0] rdata;
    logic                   rfix;
    logic                   rvalid;
  } asep_ctrl_s;

  asep_ctrl_s s_r;
  asep_ctrl_s s_nxt;
  logic       take;

  asep_tmr_if tmr_if ();

  asep_timer u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .tmr       (tmr_if.tmr)
  );

  // ==========================================================
  // Request acceptance
  // No access asleep
  assign req_ready_o = ce_i && (s_r.state == ASEP_IDLE) && !sleep_req_i;
  assign take        = req_ready_o && req_valid_i;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_nxt              = s_r;
    tmr_if.load        = 1'b0;
    tmr_if.value       = ASEP_RST_TMR;
    if (ce_i)
    begin
      // Pin inputs pass two flops before use
      s_nxt.sd1    = mem_data_i;
      s_nxt.sd2    = s_r.sd1;
      s_nxt.sf1    = ecc_fixup_flag_i;
      s_nxt.sf2    = s_r.sf1;
      s_nxt.rvalid = 1'b0;
      case (s_r.state)
        ASEP_IDLE:
        begin
          if (sleep_req_i)
          begin
            s_nxt.ds_n   = 1'b0;
            s_nxt.state  = ASEP_SLP_ENTER;
            tmr_if.load  = 1'b1;
            tmr_if.value = ASEP_TMR_W'(DS_CYC - 1);
          end
          else if (take && req_write_i)
          begin
            s_nxt.addr    = req_addr_i;
            s_nxt.wdata   = req_wdata_i;
            s_nxt.data_oe = 1'b1;
            s_nxt.cs_n    = 1'b0;
            s_nxt.we_n    = 1'b0;
            s_nxt.lanes_n = (req_be_i == 2'h0) ? 2'h0 : ~req_be_i;
            s_nxt.state   = ASEP_WR;
            tmr_if.load   = 1'b1;
            tmr_if.value  = ASEP_TMR_W'(ASEP_WE_CYC - 1);
          end
          else if (take)
          begin
            s_nxt.addr    = req_addr_i;
            s_nxt.cs_n    = 1'b0;
            s_nxt.oe_n    = 1'b0;
            s_nxt.lanes_n = (req_be_i == 2'h0) ? 2'h0 : ~req_be_i;
            s_nxt.state   = ASEP_RD;
            tmr_if.load   = 1'b1;
            tmr_if.value  = ASEP_TMR_W'(ASEP_RD_CYC - 1);
          end
        end
        ASEP_RD:
        begin
          if (tmr_if.done)
          begin
            s_nxt.rdata   = s_r.sd2;
            s_nxt.rfix    = s_r.sf2;
            s_nxt.rvalid  = 1'b1;
            s_nxt.cs_n    = 1'b1;
            s_nxt.oe_n    = 1'b1;
            s_nxt.lanes_n = 2'h3;
            s_nxt.state   = ASEP_TURN;
            tmr_if.load   = 1'b1;
            tmr_if.value  = ASEP_TMR_W'(ASEP_HZOE_CYC - 1);
          end
        end
        ASEP_TURN:
        begin
          if (tmr_if.done)
            s_nxt.state = ASEP_IDLE;
        end
        ASEP_WR:
        begin
          if (tmr_if.done)
          begin
            s_nxt.we_n  = 1'b1;
            s_nxt.state = ASEP_WR_HOLD;
          end
        end
        ASEP_WR_HOLD:
        begin
          s_nxt.data_oe = 1'b0;
          s_nxt.cs_n    = 1'b1;
          s_nxt.lanes_n = 2'h3;
          s_nxt.state   = ASEP_IDLE;
        end
        ASEP_SLP_ENTER:
        begin
          if (tmr_if.done)
            s_nxt.state = ASEP_SLEEP;
        end
        ASEP_SLEEP:
        begin
          if (!sleep_req_i)
          begin
            s_nxt.ds_n   = 1'b1;
            s_nxt.cs_n   = 1'b1;
            s_nxt.state  = ASEP_WAKE;
            tmr_if.load  = 1'b1;
            tmr_if.value = ASEP_TMR_W'(DSCA_CYC - 1);
          end
        end
        ASEP_WAKE:
        begin
          if (tmr_if.done)
            s_nxt.state = ASEP_IDLE;
        end
        default:
        begin
          s_nxt.state = ASEP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      s_r.state   <= ASEP_IDLE;
      s_r.addr    <= ASEP_RST_ADDR;
      s_r.wdata   <= ASEP_RST_DATA;
      s_r.data_oe <= 1'b0;
      s_r.cs_n    <= ASEP_RST_PIN_N;
      s_r.oe_n    <= ASEP_RST_PIN_N;
      s_r.we_n    <= ASEP_RST_PIN_N;
      s_r.lanes_n <= 2'h3;
      s_r.ds_n    <= ASEP_RST_PIN_N;
      s_r.sd1     <= ASEP_RST_DATA;
      s_r.sd2     <= ASEP_RST_DATA;
      s_r.sf1     <= 1'b0;
      s_r.sf2     <= 1'b0;
      s_r.rdata   <= ASEP_RST_DATA;
      s_r.rfix    <= 1'b0;
      s_r.rvalid  <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rsp_valid_o        = s_r.rvalid;
  assign rsp_rdata_o        = s_r.rdata;
  assign rsp_ecc_fix_o      = s_r.rfix;
  assign awake_o            = (s_r.state != ASEP_SLP_ENTER) &&
                              (s_r.state != ASEP_SLEEP) &&
                              (s_r.state != ASEP_WAKE);
  assign mem_addr_o         = s_r.addr;
  assign chip_select_n_o    = s_r.cs_n;
  assign drive_enable_n_o   = s_r.oe_n;
  assign write_strobe_n_o   = s_r.we_n;
  assign low_byte_lane_n_o  = s_r.lanes_n[0];
  assign high_byte_lane_n_o = s_r.lanes_n[1];
  assign deep_sleep_n_o     = s_r.ds_n;
  assign mem_data_o         = s_r.wdata;
  assign mem_data_oe_o      = s_r.data_oe;

endmodule : asep_ctrl

`default_nettype wire

// [core/asep_pkg.sv]
// Constants, types and timing for the static memory port controller.
// Assumes a 125 MHz clock; all counts derive from the 8 ns period.

package asep_pkg;

  // ==========================================================
  // Widths
  localparam int ASEP_ADDR_W = 18;
  localparam int ASEP_DATA_W = 16;
  localparam int ASEP_TMR_W  = 17;

  // ==========================================================
  // Memory timing and derived cycle counts
  localparam int ASEP_CLK_NS     = 8;
  localparam int ASEP_T_AA_NS    = 10;
  localparam int ASEP_T_HZWE_NS  = 5;
  localparam int ASEP_T_SD_NS    = 5;
  localparam int ASEP_T_HZOE_NS  = 5;
  localparam int ASEP_T_DS_MS    = 1;
  localparam int ASEP_T_DSCA_US  = 300;
  localparam int ASEP_SYNC_STAGES = 2;

  localparam int ASEP_ACC_CYC =
    (ASEP_T_AA_NS + ASEP_CLK_NS - 1) / ASEP_CLK_NS;
  localparam int ASEP_RD_CYC  = ASEP_ACC_CYC + ASEP_SYNC_STAGES;
  localparam int ASEP_WE_CYC  =
    (ASEP_T_HZWE_NS + ASEP_T_SD_NS + ASEP_CLK_NS - 1) / ASEP_CLK_NS;
  localparam int ASEP_HZOE_CYC =
    (ASEP_T_HZOE_NS + ASEP_CLK_NS - 1) / ASEP_CLK_NS;
  localparam int ASEP_DS_CYC =
    (ASEP_T_DS_MS * 1000000 + ASEP_CLK_NS - 1) / ASEP_CLK_NS;
  localparam int ASEP_DSCA_CYC =
    (ASEP_T_DSCA_US * 1000 + ASEP_CLK_NS - 1) / ASEP_CLK_NS;

  // ==========================================================
  // Reset values
  localparam logic                   ASEP_RST_PIN_N = 1'b1;
  localparam logic [ASEP_DATA_W-1:0] ASEP_RST_DATA  = 16'h0000;
  localparam logic [ASEP_ADDR_W-1:0] ASEP_RST_ADDR  = 18'h00000;
  localparam logic [ASEP_TMR_W-1:0]  ASEP_RST_TMR   = 17'h00000;

  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ASEP_IDLE,
    ASEP_RD,
    ASEP_TURN,
    ASEP_WR,
    ASEP_WR_HOLD,
    ASEP_SLP_ENTER,
    ASEP_SLEEP,
    ASEP_WAKE
  } asep_state_e;

endpackage : asep_pkg

// [core/asep_tmr_if.sv]
// Load and done signals between the controller and its wait timer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface asep_tmr_if;
  logic                           load;
  logic [asep_pkg::ASEP_TMR_W-1:0] value;
  logic                           done;

  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : asep_tmr_if

`default_nettype wire

// [core/asep_timer.sv]
// Down-counting wait timer; done is high while the count is zero.
// Assumes load and value come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module asep_timer (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  asep_tmr_if.tmr   tmr
);
  import asep_pkg::*;

  typedef struct packed {
    logic [ASEP_TMR_W-1:0] cnt;
  } asep_tmr_s;

  asep_tmr_s s_r;
  asep_tmr_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (ce_i)
    begin
      if (tmr.load)
        s_nxt.cnt = tmr.value;
      else if (s_r.cnt != ASEP_RST_TMR)
        s_nxt.cnt = s_r.cnt - 17'h00001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      s_r.cnt <= ASEP_RST_TMR;
    else
      s_r <= s_nxt;
  end

  assign tmr.done = (s_r.cnt == ASEP_RST_TMR);

endmodule : asep_timer

`default_nettype wire

// [bench/asep_ctrl_assertions.sv]
// Pin-level assertions for the memory port controller.
// Assumes binding into asep_ctrl; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module asep_ctrl_chk #(
  parameter int DS_CYC   = 8,
  parameter int DSCA_CYC = 6
) (
  input wire logic                             clk_i,
  input wire logic                             reset_n_i,
  input wire logic                             ce_i,
  input wire logic                             req_valid_i,
  input wire logic                             req_ready_o,
  input wire logic                             req_write_i,
  input wire logic [1:0]                       req_be_i,
  input wire logic                             rsp_valid_o,
  input wire logic                             sleep_req_i,
  input wire logic [asep_pkg::ASEP_ADDR_W-1:0] mem_addr_o,
  input wire logic                             chip_select_n_o,
  input wire logic                             drive_enable_n_o,
  input wire logic                             write_strobe_n_o,
  input wire logic                             low_byte_lane_n_o,
  input wire logic                             deep_sleep_n_o,
  input wire logic                             mem_data_oe_o
);
  import asep_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic take_w;
  int   low_r;
  int   up_r;
  assign take_w = req_valid_i && req_ready_o;
  // =====
  // Sleep length and wake wait counters
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || deep_sleep_n_o)
      low_r <= 0;
    else
      low_r <= low_r + 1;
    if (!reset_n_i)
      up_r <= DSCA_CYC;
    else if (!deep_sleep_n_o)
      up_r <= 0;
    else if (up_r < DSCA_CYC)
      up_r <= up_r + 1;
  end
  // =====
  // Checks
  chk_read_pins: assert property (
    take_w && !req_write_i |=> !chip_select_n_o && !drive_enable_n_o
      && write_strobe_n_o && low_byte_lane_n_o == ($past(req_be_i) == 2'h2)
  ) else $error("read pins wrong");
  chk_read_answer: assert property (
    take_w && !req_write_i |=> !rsp_valid_o [*4] ##1 rsp_valid_o
  ) else $error("read answer late");
  chk_write_pulse: assert property (
    take_w && req_write_i |=>
      (!write_strobe_n_o && !chip_select_n_o && mem_data_oe_o) [*2]
  ) else $error("write pulse wrong");
  chk_write_end: assert property (
    take_w && req_write_i |-> ##3 write_strobe_n_o && mem_data_oe_o
      ##1 !mem_data_oe_o && chip_select_n_o
  ) else $error("write end wrong");
  chk_no_clash: assert property (
    mem_data_oe_o |-> chip_select_n_o || drive_enable_n_o || !write_strobe_n_o
  ) else $error("bus clash");
  chk_addr_held: assert property (
    !chip_select_n_o && $past(!chip_select_n_o) |-> $stable(mem_addr_o)
  ) else $error("address moved");
  chk_sleep_hold: assert property (
    $rose(deep_sleep_n_o) |-> low_r >= DS_CYC
  ) else $error("sleep too short");
  chk_wake_wait: assert property (
    up_r < DSCA_CYC |-> chip_select_n_o && !req_ready_o
  ) else $error("access too soon");
  chk_refuse_idle: assert property (
    !ce_i || sleep_req_i |-> !req_ready_o
  ) else $error("request not refused");
  cov_read: cover property (take_w && !req_write_i);
  cov_write: cover property (take_w && req_write_i);
  cov_wake: cover property ($rose(deep_sleep_n_o));
endmodule : asep_ctrl_chk
`default_nettype wire

// [bench/asep_mem_model.sv]
// Behavioural static memory with byte lanes, sleep pin and error flag.
// Assumes controller pins in; bus_o is the resolved data wire.
`timescale 1ns/1ns
`default_nettype none
module asep_mem_model #(
  parameter int DLY = 3
) (
  input  wire logic        clk_i,
  input  wire logic [17:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        lb_n_i,
  input  wire logic        hb_n_i,
  input  wire logic        ds_n_i,
  input  wire logic [15:0] hd_i,
  input  wire logic        hoe_i,
  input  wire logic        err_i,
  output logic [15:0]      bus_o,
  output logic             flag_o
);
  logic [15:0] mem [16];
  logic        tog = 1'b0;
  logic        rd;
  logic        wr;
  logic [15:0] junk;
  // Undriven wire shows a moving pattern
  always @(posedge clk_i) tog <= ~tog;
  assign junk = {8{tog, ~tog}};
  assign rd = ds_n_i && !cs_n_i && !oe_n_i && we_n_i;
  assign wr = ds_n_i && !cs_n_i && !we_n_i;
  always @*
  begin
    if (wr && !lb_n_i) mem[addr_i[3:0]][7:0] = bus_o[7:0];
    if (wr && !hb_n_i) mem[addr_i[3:0]][15:8] = bus_o[15:8];
  end
  assign #DLY bus_o[7:0] = (rd && !lb_n_i) ?
    (hoe_i ? 8'hxx : mem[addr_i[3:0]][7:0]) : hoe_i ? hd_i[7:0] : junk[7:0];
  assign #DLY bus_o[15:8] = (rd && !hb_n_i) ?
    (hoe_i ? 8'hxx : mem[addr_i[3:0]][15:8]) : hoe_i ? hd_i[15:8] : junk[15:8];
  assign #DLY flag_o = rd ? err_i : tog;
endmodule : asep_mem_model
`default_nettype wire

// [bench/asep_ctrl_test.sv]
// Self-checking bench for the static memory port controller.
// Assumes the behavioural memory model and the pin checker.
`timescale 1ns/1ns
`default_nettype none
module asep_ctrl_test;
  import asep_pkg::*;
  localparam int DS   = 8;
  localparam int DSCA = 6;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [ASEP_ADDR_W-1:0] req_addr_i = 18'h00000;
  logic [ASEP_DATA_W-1:0] req_wdata_i = 16'h0000;
  logic [1:0] req_be_i = 2'h3;
  logic sleep_req_i = 1'b0;
  logic err_i = 1'b0;
  logic req_ready_o, rsp_valid_o, rsp_ecc_fix_o, awake_o, got_f;
  logic [15:0] rsp_rdata_o, mem_data_o, mem_data_i, got_d;
  logic [17:0] mem_addr_o;
  logic chip_select_n_o, drive_enable_n_o, write_strobe_n_o;
  logic low_byte_lane_n_o, high_byte_lane_n_o, deep_sleep_n_o;
  logic mem_data_oe_o, ecc_fixup_flag_i;
  int failures = 0;
  int n_tests = 0;

  asep_ctrl #(.DS_CYC(DS), .DSCA_CYC(DSCA)) dut (.*);
  asep_mem_model mem (.clk_i(clk_i), .addr_i(mem_addr_o),
    .cs_n_i(chip_select_n_o), .oe_n_i(drive_enable_n_o),
    .we_n_i(write_strobe_n_o), .lb_n_i(low_byte_lane_n_o),
    .hb_n_i(high_byte_lane_n_o), .ds_n_i(deep_sleep_n_o),
    .hd_i(mem_data_o), .hoe_i(mem_data_oe_o), .err_i(err_i),
    .bus_o(mem_data_i), .flag_o(ecc_fixup_flag_i));

  initial forever #4 clk_i = ~clk_i;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // One request, held until taken; reads wait for the answer
  task automatic access(input logic w, input logic [17:0] a,
                        input logic [15:0] d, input logic [1:0] be);
    int n;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_be_i <= be;
    @(negedge clk_i);
    for (n = 0; n < 60 && req_ready_o !== 1'b1; n++)
      @(negedge clk_i);
    check(req_ready_o, 1'b1);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    if (w)
      return;
    for (n = 0; n < 20 && rsp_valid_o !== 1'b1; n++)
      @(negedge clk_i);
    check(n < 20, 1'b1);
    got_d = rsp_rdata_o;
    got_f = rsp_ecc_fix_o;
  endtask : access

  task automatic t_rw;
    @(negedge clk_i);
    check({chip_select_n_o, deep_sleep_n_o, mem_data_oe_o}, 16'h0006);
    access(1'b1, 18'h00001, 16'h1234, 2'h3);
    access(1'b1, 18'h00002, 16'hbeef, 2'h0);
    access(1'b0, 18'h00001, 16'h0000, 2'h3);
    check(got_d, 16'h1234);
    check(got_f, 1'b0);
    access(1'b0, 18'h00002, 16'h0000, 2'h3);
    check(got_d, 16'hbeef);
    $display("done read write");
  endtask : t_rw

  // Clock enable low: request waits, pins stay in standby
  task automatic t_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    req_valid_i <= 1'b1;
    req_write_i <= 1'b0;
    req_addr_i <= 18'h00001;
    req_be_i <= 2'h3;
    repeat (3) @(negedge clk_i);
    check({req_ready_o, chip_select_n_o}, 16'h0001);
    @(posedge clk_i);
    ce_i <= 1'b1;
    req_valid_i <= 1'b0;
    access(1'b0, 18'h00001, 16'h0000, 2'h3);
    check(got_d, 16'h1234);
    $display("done clock enable");
  endtask : t_freeze

  task automatic t_lanes;
    access(1'b1, 18'h00001, 16'haa55, 2'h1);
    access(1'b1, 18'h00001, 16'hcc77, 2'h2);
    access(1'b0, 18'h00001, 16'h0000, 2'h3);
    check(got_d, 16'hcc55);
    access(1'b0, 18'h00001, 16'h0000, 2'h2);
    check(got_d[15:8], 8'hcc);
    @(posedge clk_i);
    err_i <= 1'b1;
    access(1'b0, 18'h00002, 16'h0000, 2'h3);
    check(got_f, 1'b1);
    err_i <= 1'b0;
    $display("done lanes and flag");
  endtask : t_lanes

  task automatic t_sleep;
    time t0;
    int  n;
    @(posedge clk_i);
    sleep_req_i <= 1'b1;
    t0 = $time;
    repeat (3) @(negedge clk_i);
    check({deep_sleep_n_o, awake_o, req_ready_o}, 16'h0000);
    repeat (DS) @(posedge clk_i);
    sleep_req_i <= 1'b0;
    for (n = 0; n < 100 && req_ready_o !== 1'b1; n++)
      @(negedge clk_i);
    check(($time - t0) / 8 >= DS + DSCA, 1'b1);
    access(1'b0, 18'h00002, 16'h0000, 2'h3);
    check(got_d, 16'hbeef);
    $display("done sleep");
  endtask : t_sleep

  // Sleep request dropped early: pin still held low for the full time
  task automatic t_nap;
    time t0;
    int  n;
    @(posedge clk_i);
    sleep_req_i <= 1'b1;
    t0 = $time;
    @(posedge clk_i);
    sleep_req_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    check({deep_sleep_n_o, awake_o, req_ready_o}, 16'h0000);
    for (n = 0; n < 100 && req_ready_o !== 1'b1; n++)
      @(negedge clk_i);
    check(16'(($time - t0) / 8), 16'(DS + DSCA + 2));
    $display("done short sleep");
  endtask : t_nap

  initial
  begin
    #100000;
    failures++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_rw();
    t_freeze();
    t_lanes();
    t_sleep();
    t_nap();
    end_sim();
  end
endmodule : asep_ctrl_test

bind asep_ctrl asep_ctrl_chk #(.DS_CYC(DS_CYC), .DSCA_CYC(DSCA_CYC)) chk (.*);
`default_nettype wire
